/* core/flk_lock_ctrl.v */
// Behaviour
// [RULE1] Block bits gate erase/program; master bit gates block bit changes.
// [RULE2] Master clear: set-block succeeds at normal or elevated level.
// [RULE3] Set-master needs elevated level, else protect/write errors.
// [RULE4] Master set: set-block needs elevated level or protect/write error.
// [RULE5] Host sets a lock-bit with setup write then confirm write.
// [RULE6] After a set sequence, reads return status until a new command.
// [RULE7] Completion shows on ready/busy pin and machine-ready status bit.
// [RULE8] Invalid set sequence sets write and erase error flags.
// [RULE9] Clear at supply lockout: bits kept, supply-low and erase errors.
// [RULE10] Clear command clears all set block lock-bits at once.
// [RULE11] Clear needs master clear or elevated level, else protect and erase.
// [RULE12] Invalid clear sequence sets write and erase error flags.
// [RULE13] After clear, host checks erase error flag, clears status if set.
// [RULE14] After set, host checks write error flag, clears status if set.
// [RULE15] Aborted clear leaves bits undefined; host must repeat the clear.
// [RULE16] No operation clears the master lock-bit once set.
// [RULE17] Erase/write allowed if block bit clear or reset pin elevated.
// [RULE18] Error flags stay set until clear-status command.
`timescale 1ns/10ps
`include "flk_defines.vh"

module flk_lock_ctrl #(
  parameter AW = 20,
  parameter POLL_LIMIT = 32'd125000000
) (
  input wire i_sys_clk, // 125 MHz clock
  input wire i_arst_n, // Async reset, active low
  input wire i_req_valid, // Operation request
  input wire [1:0] i_req_op, // Operation code
  input wire [AW-1:0] i_req_addr, // Address within target block
  input wire i_override, // Ask for elevated reset level
  output wire o_req_ready, // Idle, request taken
  output reg o_done, // Operation finished pulse
  output reg [7:0] o_status, // Final status byte
  output reg o_ok, // No error in status
  output reg o_timeout, // Device never became ready
  output reg o_abort_retry, // Clear aborted, repeat it
  input wire i_ready_busy_output, // Device ready/busy pin
  input wire [7:0] i_dq_in, // Device data pins in
  output wire [7:0] o_dq_out, // Device data pins out
  output wire o_dq_oe_n, // Low while driving data
  output wire [AW-1:0] o_addr, // Device address pins
  output wire o_we_n, // Device write enable
  output wire o_oe_n, // Device output enable
  output wire o_ce_n, // Device chip enable
  output reg o_reset_powerdown_pin, // Reset pin, normal high
  output reg o_elevated_override_level // Drive reset to elevated
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_reg;
  wire rst_n;
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  reg [8:0] pin_s1_reg;
  reg [8:0] pin_s2_reg;
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
    end
    else
    begin
      pin_s1_reg <= {i_ready_busy_output, i_dq_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ----------------------------------------
  // Bus cycle engine
  // ----------------------------------------
  reg cyc_start_reg;
  reg cyc_write_reg;
  reg [7:0] cyc_data_reg;
  reg [AW-1:0] cyc_addr_reg;
  wire cyc_done;
  wire [7:0] cyc_rdata;

  flk_bus_cycle #(.AW(AW)) u_cycle (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_start(cyc_start_reg),
    .i_write(cyc_write_reg),
    .i_addr(cyc_addr_reg),
    .i_wdata(cyc_data_reg),
    .i_dq_in(pin_s2_reg[7:0]),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe_n(o_dq_oe_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n),
    .o_ce_n(o_ce_n),
    .o_rdata(cyc_rdata),
    .o_done(cyc_done)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_CONFIRM = 3'h2;
  localparam [2:0] ST_POLL = 3'h3;
  localparam [2:0] ST_READ = 3'h4;
  localparam [2:0] ST_CLRST = 3'h5;
  localparam [2:0] ST_ARRAY = 3'h6;
  localparam [2:0] ST_FINISH = 3'h7;

  reg [2:0] state_reg;
  reg [1:0] op_reg;
  reg [31:0] poll_cnt_reg;
  wire [7:0] err_mask;
  wire sr_err;

  assign o_req_ready = (state_reg == ST_IDLE);
  assign err_mask = (8'h01 << `FLK_SR_ERASE_CLR) | (8'h01 << `FLK_SR_WRITE_SET)
    | (8'h01 << `FLK_SR_SUPPLY_LOW) | (8'h01 << `FLK_SR_PROTECT);
  assign sr_err = |(cyc_rdata & err_mask);

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      op_reg <= 2'h0;
      poll_cnt_reg <= 32'h00000000;
      cyc_start_reg <= 1'b0;
      cyc_write_reg <= 1'b0;
      cyc_data_reg <= 8'h00;
      cyc_addr_reg <= {AW{1'b0}};
      o_done <= 1'b0;
      o_status <= 8'h00;
      o_ok <= 1'b0;
      o_timeout <= 1'b0;
      o_abort_retry <= 1'b0;
      o_reset_powerdown_pin <= 1'b1;
      o_elevated_override_level <= 1'b0;
    end
    else
    begin
      cyc_start_reg <= 1'b0;
      o_done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (i_req_valid)
          begin
            op_reg <= i_req_op;
            cyc_addr_reg <= i_req_addr;
            o_timeout <= 1'b0;
            o_abort_retry <= 1'b0;
            // Master set needs elevated level; caller may also ask
            o_elevated_override_level <= i_override // see [RULE4] [RULE11]
              | (i_req_op == `FLK_OP_SET_MASTER); // see [RULE3]
            cyc_write_reg <= 1'b1;
            cyc_start_reg <= 1'b1;
            if (i_req_op == `FLK_OP_CLR_STATUS)
            begin
              cyc_data_reg <= `FLK_CMD_CLEAR_STATUS; // see [RULE18]
              state_reg <= ST_CLRST;
            end
            else
            begin
              cyc_data_reg <= `FLK_CMD_LOCK_SETUP; // see [RULE5]
              state_reg <= ST_SETUP;
            end
          end
        end
        ST_SETUP:
          if (cyc_done)
          begin
            cyc_start_reg <= 1'b1;
            case (op_reg) // see [RULE5] [RULE10]
              `FLK_OP_SET_BLOCK: cyc_data_reg <= `FLK_CMD_SET_BLOCK;
              `FLK_OP_SET_MASTER: cyc_data_reg <= `FLK_CMD_SET_MASTER;
              default: cyc_data_reg <= `FLK_CMD_CLEAR_CONFIRM;
            endcase
            state_reg <= ST_CONFIRM;
          end
        ST_CONFIRM:
          if (cyc_done)
          begin
            poll_cnt_reg <= 32'h00000000;
            state_reg <= ST_POLL;
          end
        ST_POLL:
        begin
          // Wait on ready/busy pin; reads would return status anyway
          poll_cnt_reg <= poll_cnt_reg + 32'h00000001;
          if (pin_s2_reg[8] && poll_cnt_reg > 32'h00000004) // see [RULE7]
          begin
            cyc_write_reg <= 1'b0;
            cyc_start_reg <= 1'b1;
            state_reg <= ST_READ;
          end
          else if (poll_cnt_reg == POLL_LIMIT)
          begin
            o_timeout <= 1'b1;
            o_abort_retry <= (op_reg == `FLK_OP_CLEAR); // see [RULE15]
            state_reg <= ST_ARRAY;
            cyc_write_reg <= 1'b1;
            cyc_data_reg <= `FLK_CMD_READ_ARRAY;
            cyc_start_reg <= 1'b1;
          end
        end
        ST_READ:
          if (cyc_done)
          begin
            if (!cyc_rdata[`FLK_SR_READY]) // see [RULE6] [RULE7]
              state_reg <= ST_POLL;
            else
            begin
              o_status <= cyc_rdata;
              o_ok <= ~sr_err; // see [RULE13] [RULE14]
              o_abort_retry <= (op_reg == `FLK_OP_CLEAR)
                & cyc_rdata[`FLK_SR_SUPPLY_LOW]; // see [RULE9] [RULE15]
              cyc_write_reg <= 1'b1;
              cyc_start_reg <= 1'b1;
              if (sr_err)
              begin
                cyc_data_reg <= `FLK_CMD_CLEAR_STATUS; // see [RULE13] [RULE14]
                state_reg <= ST_CLRST;
              end
              else
              begin
                cyc_data_reg <= `FLK_CMD_READ_ARRAY;
                state_reg <= ST_ARRAY;
              end
            end
          end
        ST_CLRST:
          if (cyc_done)
          begin
            if (op_reg == `FLK_OP_CLR_STATUS)
            begin
              o_status <= 8'h00;
              o_ok <= 1'b1;
            end
            cyc_write_reg <= 1'b1;
            cyc_data_reg <= `FLK_CMD_READ_ARRAY;
            cyc_start_reg <= 1'b1;
            state_reg <= ST_ARRAY;
          end
        ST_ARRAY:
          if (cyc_done)
            state_reg <= ST_FINISH;
        ST_FINISH:
        begin
          o_elevated_override_level <= 1'b0;
          o_done <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // flk_lock_ctrl

/* core/flk_defines.vh */
`ifndef FLK_DEFINES_VH
`define FLK_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FLK_CMD_LOCK_SETUP 8'h60
`define FLK_CMD_SET_BLOCK 8'h01
`define FLK_CMD_SET_MASTER 8'hF1
`define FLK_CMD_CLEAR_CONFIRM 8'hD0
`define FLK_CMD_CLEAR_STATUS 8'h50
`define FLK_CMD_READ_ARRAY 8'hFF

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define FLK_SR_READY 7
`define FLK_SR_ERASE_CLR 5
`define FLK_SR_WRITE_SET 4
`define FLK_SR_SUPPLY_LOW 3
`define FLK_SR_PROTECT 1

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define FLK_OP_SET_BLOCK 2'h0
`define FLK_OP_SET_MASTER 2'h1
`define FLK_OP_CLEAR 2'h2
`define FLK_OP_CLR_STATUS 2'h3

// ----------------------------------------
// Bus timing in ns, and cycles at 125 MHz
// ----------------------------------------
`define FLK_CLK_NS 8
`define FLK_WE_PULSE_NS 50
`define FLK_WE_CYC ((`FLK_WE_PULSE_NS + `FLK_CLK_NS - 1) / `FLK_CLK_NS)
`define FLK_RD_ACCESS_NS 90
`define FLK_RD_CYC ((`FLK_RD_ACCESS_NS + `FLK_CLK_NS - 1) / `FLK_CLK_NS)

`endif

/* core/flk_bus_cycle.v */
`timescale 1ns/10ps
`include "flk_defines.vh"

// ----------------------------------------
// One write or read cycle on the flash pins
// ----------------------------------------
module flk_bus_cycle #(
  parameter AW = 20
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Synchronous-released reset
  input wire i_start, // Start a cycle
  input wire i_write, // 1 write, 0 read
  input wire [AW-1:0] i_addr, // Address
  input wire [7:0] i_wdata, // Write data
  input wire [7:0] i_dq_in, // Data pins, synchronised
  output reg [AW-1:0] o_addr, // Address pins
  output reg [7:0] o_dq_out, // Data pins out
  output reg o_dq_oe_n, // Low while driving data
  output reg o_we_n, // Write enable pin
  output reg o_oe_n, // Output enable pin
  output reg o_ce_n, // Chip enable pin
  output reg [7:0] o_rdata, // Read result
  output wire o_done // Cycle finished pulse
);
  localparam integer WE_CYC_I = `FLK_WE_CYC;
  // Two extra cycles cover the data pin synchroniser
  localparam integer RD_CYC_I = `FLK_RD_CYC + 32'h00000002;
  localparam [7:0] WE_CYC = WE_CYC_I[7:0];
  localparam [7:0] RD_CYC = RD_CYC_I[7:0];
  reg [7:0] cnt_reg;
  reg busy_reg;
  reg wr_reg;
  reg done_reg;

  assign o_done = done_reg;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      o_addr <= {AW{1'b0}};
      o_dq_out <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_ce_n <= 1'b1;
      o_rdata <= 8'h00;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!busy_reg && i_start)
      begin
        busy_reg <= 1'b1;
        wr_reg <= i_write;
        cnt_reg <= i_write ? WE_CYC : RD_CYC;
        o_addr <= i_addr;
        o_dq_out <= i_wdata;
        o_dq_oe_n <= ~i_write;
        o_we_n <= ~i_write;
        o_oe_n <= i_write;
        o_ce_n <= 1'b0;
      end
      else if (busy_reg)
      begin
        if (cnt_reg != 8'h00)
          cnt_reg <= cnt_reg - 8'h01;
        else
        begin
          // Data latched on the rising edge of write enable
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          o_we_n <= 1'b1;
          o_oe_n <= 1'b1;
          o_ce_n <= 1'b1;
          o_dq_oe_n <= 1'b1;
          if (!wr_reg)
            o_rdata <= i_dq_in;
        end
      end
    end
  end
endmodule // flk_bus_cycle

/* tb/flk_lock_monitor.sv */
`timescale 1ns/10ps

// ----------------------------
// Port checks
// ----------------------------
module flk_lock_monitor (
  input wire logic i_sys_clk, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic i_req_valid, // Request
  input wire logic [1:0] i_req_op, // Op
  input wire logic o_req_ready, // Idle
  input wire logic o_done, // Done
  input wire logic [7:0] o_status, // Status
  input wire logic o_ok, // No error
  input wire logic o_dq_oe_n, // Drive
  input wire logic o_we_n, // Write
  input wire logic o_oe_n, // Read
  input wire logic o_ce_n, // Select
  input wire logic o_reset_powerdown_pin, // Reset pin
  input wire logic o_elevated_override_level // Elevated
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  sequence we_held_s;
    !o_we_n [*8] ##1 o_we_n;
  endsequence
  sequence op_run_s;
    !o_req_ready ##[1:400] o_done;
  endsequence
  op_done_a:
    assert property (o_req_ready && i_req_valid |=> op_run_s)
    else $error("no done");
  done_pulse_a:
    assert property (o_done |=> !o_done) else $error("long done");
  we_width_a:
    assert property ($fell(o_we_n) |-> we_held_s) else $error("we width");
  strobe_excl_a:
    assert property (o_we_n || o_oe_n) else $error("we and oe");
  write_drive_a:
    assert property (!o_we_n |-> !o_ce_n && !o_dq_oe_n)
    else $error("write undriven");
  read_float_a:
    assert property (!o_oe_n |-> o_dq_oe_n) else $error("read clash");
  reset_pin_a:
    assert property (o_reset_powerdown_pin) else $error("reset pin low");
  ok_flag_a:
    assert property (o_done |-> o_ok == ((o_status & 8'h3A) == 8'h00))
    else $error("ok flag");
  master_hv_a:
    assert property (o_req_ready && i_req_valid && i_req_op == 2'h1
      |-> ##[1:20] o_elevated_override_level) else $error("no elevated");
endmodule // flk_lock_monitor

bind flk_lock_ctrl flk_lock_monitor flk_lock_monitor_i (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
  .i_req_op(i_req_op), .o_req_ready(o_req_ready), .o_done(o_done),
  .o_status(o_status), .o_ok(o_ok), .o_dq_oe_n(o_dq_oe_n),
  .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_ce_n(o_ce_n),
  .o_reset_powerdown_pin(o_reset_powerdown_pin),
  .o_elevated_override_level(o_elevated_override_level));

/* tb/flk_flash_model.sv */
`timescale 1ns/10ps
`include "flk_defines.vh"

// ----------------------------
// Flash device lock logic
// ----------------------------
module flk_flash_model (
  input wire logic i_clk, // Clock
  input wire logic [19:0] i_addr, // Address
  input wire logic [7:0] i_dq, // Data bus
  input wire logic i_we_n, // Write
  input wire logic i_oe_n, // Read
  input wire logic i_ce_n, // Select
  input wire logic i_hv, // Elevated
  input wire logic i_vpp_low, // Supply low
  output logic [7:0] o_dq, // Data out
  output logic o_ready // Ready pin
);
  logic [3:0] lock_reg = 4'h0;
  logic master_reg = 1'h0;
  logic setup_reg = 1'h0;
  logic arm_reg = 1'h0;
  logic [7:0] cmd_reg = 8'h00;
  logic [1:0] blk_reg = 2'h0;
  logic [3:0] busy_reg = 4'h0;
  logic [7:0] sr_reg = 8'h00;
  logic [3:0] wr_en;
  initial o_dq = 8'h00;
  assign o_ready = (busy_reg == 4'h0);
  // Erase/write enable per block: lock clear or override
  assign wr_en = ~lock_reg | {4{i_hv}};
  always @(posedge i_clk)
  begin
    if (busy_reg != 4'h0)
      busy_reg <= busy_reg - 4'h1;
    // Status on any read, toggling when released
    o_dq <= (!i_ce_n && !i_oe_n) ? {o_ready, sr_reg[6:0]}
      : ~o_dq;
    if (!i_we_n && !i_ce_n)
    begin
      arm_reg <= 1'h1;
      cmd_reg <= i_dq;
      blk_reg <= i_addr[19:18];
    end
    else if (arm_reg)
    begin
      arm_reg <= 1'h0;
      setup_reg <= !setup_reg && cmd_reg == `FLK_CMD_LOCK_SETUP;
      if (setup_reg)
      begin
        busy_reg <= 4'hC;
        case (cmd_reg)
          `FLK_CMD_SET_BLOCK:
            if (master_reg && !i_hv)
              sr_reg <= sr_reg | 8'h12;
            else
              lock_reg[blk_reg] <= 1'h1;
          `FLK_CMD_SET_MASTER:
            if (!i_hv)
              sr_reg <= sr_reg | 8'h12;
            else
              master_reg <= 1'h1;
          `FLK_CMD_CLEAR_CONFIRM:
            if (i_vpp_low)
              sr_reg <= sr_reg | 8'h28;
            else if (master_reg && !i_hv)
              sr_reg <= sr_reg | 8'h22;
            else
              lock_reg <= 4'h0;
          default:
            sr_reg <= sr_reg | 8'h30;
        endcase
      end
      else if (cmd_reg == `FLK_CMD_CLEAR_STATUS)
        sr_reg <= 8'h00;
    end
  end
endmodule // flk_flash_model

/* tb/test_flk_lock_ctrl.sv */
`timescale 1ns/10ps

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module test_flk_lock_ctrl;
  logic i_sys_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic i_req_valid = 1'h0;
  logic [1:0] i_req_op = 2'h0;
  logic [19:0] i_req_addr = 20'h00000;
  logic i_override = 1'h0;
  logic vpp_low = 1'h0;
  wire o_req_ready, o_done, o_ok, o_abort_retry, o_timeout, o_dq_oe_n;
  wire o_we_n, o_oe_n, o_ce_n, ready_pin, rp_pin, hv;
  wire [7:0] o_status, dq_host, dq_dev, dq_bus;
  wire [19:0] o_addr;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  // Per test: op, block, override, supply low, status, lock bits
  logic [1:0] t_op [9] = '{0, 0, 1, 0, 0, 2, 2, 2, 3};
  logic [1:0] t_blk [9] = '{0, 1, 0, 2, 2, 0, 0, 0, 0};
  logic [8:0] t_ovr = 9'h0D2;
  logic [8:0] t_vpp = 9'h040;
  logic [7:0] t_sr [9] = '{8'h80, 8'h80, 8'h80, 8'h92, 8'h80, 8'hA2, 8'hA8,
    8'h80, 8'h00};
  logic [3:0] t_lk [9] = '{1, 3, 3, 3, 7, 7, 7, 0, 0};
  assign dq_bus = !o_dq_oe_n ? dq_host : dq_dev;

  flk_lock_ctrl #(.AW(20), .POLL_LIMIT(32'd200)) flk_lock_ctrl_i (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .i_req_addr(i_req_addr), .i_override(i_override),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_status(o_status),
    .o_ok(o_ok), .o_timeout(o_timeout), .o_abort_retry(o_abort_retry),
    .i_ready_busy_output(ready_pin), .i_dq_in(dq_bus), .o_dq_out(dq_host),
    .o_dq_oe_n(o_dq_oe_n), .o_addr(o_addr), .o_we_n(o_we_n),
    .o_oe_n(o_oe_n), .o_ce_n(o_ce_n), .o_reset_powerdown_pin(rp_pin),
    .o_elevated_override_level(hv));
  flk_flash_model flk_flash_model_i (
    .i_clk(i_sys_clk), .i_addr(o_addr), .i_dq(dq_bus), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_ce_n(o_ce_n), .i_hv(hv), .i_vpp_low(vpp_low),
    .o_dq(dq_dev), .o_ready(ready_pin));

  initial forever #4 i_sys_clk = ~i_sys_clk;

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic run_op(input int k);
    @(posedge i_sys_clk);
    vpp_low <= t_vpp[k];
    i_req_valid <= 1'h1;
    i_req_op <= t_op[k];
    i_req_addr <= {t_blk[k], 18'h00123};
    i_override <= t_ovr[k];
    @(posedge i_sys_clk);
    i_req_valid <= 1'h0;
    n = 0;
    while (o_done !== 1'h1 && n < 1000)
    begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask

  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("[ERR] run time exp 4999 got %0d", cycles);
      test_done();
    end
  end

  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    for (int k = 0; k < 9; k++)
    begin
      run_op(k);
      `CHK("done", 1'h1, o_done)
      `CHK("status", t_sr[k], o_status)
      `CHK("ok", (t_sr[k] & 8'h3A) == 8'h00, o_ok)
      `CHK("retry", t_sr[k][3], o_abort_retry)
      `CHK("timeout", 1'h0, o_timeout)
      `CHK("locks", t_lk[k], flk_flash_model_i.lock_reg)
      `CHK("wr gate", ~t_lk[k], flk_flash_model_i.wr_en)
      $display("test %0d done", k);
    end
    `CHK("master", 1'h1, flk_flash_model_i.master_reg)
    test_done();
  end
endmodule // test_flk_lock_ctrl
